// ---- rtl/cksrs_defines.svh ----
// constants for the clock switch and reset sequencer
// assumes inclusion by bare name from the rtl folder
`ifndef CKSRS_DEFINES_SVH
`define CKSRS_DEFINES_SVH

// register byte offsets on the wishbone slave
`define CKSRS_OFF_CTRL   8'h00
`define CKSRS_OFF_STAT   8'h04
`define CKSRS_OFF_TRIM   8'h08
`define CKSRS_OFF_IRQS   8'h0c
`define CKSRS_OFF_IRQM   8'h10

// control register fields
`define CKSRS_CTRL_SEL     0
`define CKSRS_CTRL_OPT_LO  1
`define CKSRS_CTRL_OPT_HI  2
`define CKSRS_CTRL_PCK_OUT 3
`define CKSRS_CTRL_PCK_DAT 4

// status register fields
`define CKSRS_ST_FAST    2
`define CKSRS_ST_SLOW    3
`define CKSRS_ST_ONFAST  4
`define CKSRS_ST_INRST   5

// trim register fields
`define CKSRS_TRIM_HI_LSB 0
`define CKSRS_TRIM_LO_LSB 8

// interrupt status bits
`define CKSRS_IRQ_SWITCH 0
`define CKSRS_IRQ_RESET  1

// reset values
`define CKSRS_CTRL_RST   5'h01
`define CKSRS_TRIM_RST   10'h200

// sequencing counts
`define CKSRS_FAST_WARM  4'h8
`define CKSRS_DLY_LONG   10'd512
`define CKSRS_DLY_SHORT  10'd256
`define CKSRS_FETCH_CYC  2'd2
`define CKSRS_FAST_RDY   2'd2
`define CKSRS_VECTOR     16'hfffe

`endif

// ---- rtl/cksrs_pkg.sv ----
// types shared by the clock switch and reset sequencer
// assumes the defines header is compiled alongside
package cksrs_pkg;
	typedef enum logic [1:0] {
		CKSRS_OPT_FAST_RC,
		CKSRS_OPT_SLOW_RC,
		CKSRS_OPT_EXT_CLK
	} cksrs_opt_type;

	typedef struct packed {
		logic ext_pulse;
		logic low_voltage_detect_reset;
		logic watchdog;
		logic illegal_code;
	} cksrs_src_type;

	typedef struct packed {
		logic fast_rc_en;
		logic wakeup_en;
		logic on_fast;
	} cksrs_osc_type;
endpackage

// ---- rtl/cksrs_top.sv ----
// clock source switch and reset sequencer with a classic wishbone slave
// assumes fast and slow oscillator ticks arrive as sys_clk synchronous pulses
// Behaviour
// - clearing select bit enables fast rc
// - four-bit counter counts eight fast ticks
// - wait slow flag clear, fast flag set
// - switch occurs on fast rc rising edge
// - stop wakeup oscillator after the switch
// - fast rc stopped when not selected
// - wakeup oscillator on in auto-wakeup halt
// - external clock keeps wakeup oscillator running
// - pin, low voltage, watchdog reset sources
// - illegal opcode or prebyte also resets
// - reset pin held low through delay
// - delay 256 or 512 cpu cycles
// - delay picked from option clock source
// - vector fetch two cycles from fffe
// - reset returns prog clock pin input
// - fast rc trimmed by 8+2 bits
// - 512 fast/external, 256 slow rc
// - slow flag set only when settled
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "cksrs_defines.svh"

module cksrs_top
	import cksrs_pkg::*;
#(
	parameter int SLOW_SETTLE = 4
) (
	input  wire logic          sys_clk,
	input  wire logic          rstn,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic      [31:0]   wb_dat_o,
	input  wire logic          wb_we_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	output logic               wb_ack_o,
	output logic               irq,
	input  wire logic          fast_rc_tick,
	input  wire logic          slow_osc_tick,
	input  wire logic          halt_awu,
	input  wire cksrs_src_type rst_src,
	input  wire logic          reset_pin_level,
	output logic               reset_pin_drive,
	output logic               reset_pin_oe,
	input  wire logic          prog_clock_pin_level,
	output logic               prog_clock_pin_drive,
	output logic               prog_clock_pin_oe,
	output logic               prog_clock_pullup,
	output cksrs_osc_type      osc,
	output logic      [7:0]    rc_trim_high,
	output logic      [1:0]    rc_trim_low,
	output logic               cpu_reset,
	output logic               vec_fetch,
	output logic      [15:0]   vec_addr
);

	typedef enum logic [2:0] {SW_SLOW, SW_WARM, SW_WAIT, SW_EDGE, SW_FAST} cksrs_sw_type;
	typedef enum logic [1:0] {RS_IDLE, RS_ACTIVE, RS_DELAY, RS_FETCH} cksrs_rs_type;

	////////////////////////////////////////////////////////////////////////////////
	// wishbone slave

	logic [4:0]  ctrl_q;
	logic [9:0]  trim_q;
	logic [1:0]  irq_st_q;
	logic [1:0]  irq_mk_q;
	logic        ack_q;
	logic        wr_ok;
	logic        rd_stat_irq;
	logic        sw_done;
	logic        rs_done;
	logic        pin_low;
	logic        slow_flag_q;
	logic        fast_flag_q;
	cksrs_sw_type sw_q;
	cksrs_rs_type rs_q;

	function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
		hit = (adr == off);
	endfunction

	// writes land on the edge where the master sees ack; read data is captured one edge earlier
	assign wr_ok       = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
	assign rd_stat_irq = wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q
		&& hit(wb_adr_i, `CKSRS_OFF_IRQS);
	assign wb_ack_o    = ack_q;

	// one wait state, every address answered, unmapped reads zero
	always_ff @(posedge sys_clk) begin
		if (!rstn || ack_q) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i && wb_stb_i;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			wb_dat_o <= 32'h0;
		end else if (wb_cyc_i && wb_stb_i && !wb_we_i && !ack_q) begin
			unique case (1'b1)
				hit(wb_adr_i, `CKSRS_OFF_CTRL): wb_dat_o <= {27'h0, ctrl_q};
				hit(wb_adr_i, `CKSRS_OFF_STAT): wb_dat_o <= {26'h0, rs_q != RS_IDLE,
					sw_q == SW_FAST, slow_flag_q, fast_flag_q, 2'b00};
				hit(wb_adr_i, `CKSRS_OFF_TRIM): wb_dat_o <= {22'h0, trim_q};
				hit(wb_adr_i, `CKSRS_OFF_IRQS): wb_dat_o <= {30'h0, irq_st_q};
				hit(wb_adr_i, `CKSRS_OFF_IRQM): wb_dat_o <= {30'h0, irq_mk_q};
				default: wb_dat_o <= 32'h0;
			endcase
		end
	end

	// control, trim and mask; the device reset returns prog pin to input
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			ctrl_q   <= `CKSRS_CTRL_RST;
			trim_q   <= `CKSRS_TRIM_RST;
			irq_mk_q <= 2'b00;
		end else begin
			if (cpu_reset) begin
				ctrl_q[`CKSRS_CTRL_PCK_OUT] <= 1'b0;
			end else if (wr_ok && hit(wb_adr_i, `CKSRS_OFF_CTRL)) begin
				ctrl_q <= wb_dat_i[4:0];
			end
			if (wr_ok && hit(wb_adr_i, `CKSRS_OFF_TRIM) && wb_sel_i[1]) begin
				trim_q <= wb_dat_i[9:0];
			end
			if (wr_ok && hit(wb_adr_i, `CKSRS_OFF_IRQM)) begin
				irq_mk_q <= wb_dat_i[1:0];
			end
		end
	end

	// sticky events, a read clears them but a new event wins
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			irq_st_q <= 2'b00;
		end else begin
			irq_st_q <= (rd_stat_irq ? 2'b00 : irq_st_q) | {rs_done, sw_done};
		end
	end

	assign irq = |(irq_st_q & irq_mk_q);

	////////////////////////////////////////////////////////////////////////////////
	// clock switch from wakeup oscillator to fast rc

	logic [3:0] warm_q;
	logic [1:0] fast_cnt_q;
	logic [2:0] settle_q;
	logic       sel_slow;
	cksrs_opt_type opt;

	assign sel_slow = ctrl_q[`CKSRS_CTRL_SEL];
	assign opt      = cksrs_opt_type'(ctrl_q[`CKSRS_CTRL_OPT_HI:`CKSRS_CTRL_OPT_LO]);

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sw_q   <= SW_SLOW;
			warm_q <= 4'h0;
		end else begin
			unique case (sw_q)
				SW_SLOW: if (!sel_slow) begin
					sw_q   <= SW_WARM;
					warm_q <= 4'h0;
				end
				SW_WARM: if (sel_slow) begin
					sw_q <= SW_SLOW;
				end else if (fast_rc_tick) begin
					warm_q <= warm_q + 4'h1;
					if (warm_q == `CKSRS_FAST_WARM - 4'h1) begin
						sw_q <= SW_WAIT;
					end
				end
				SW_WAIT: if (sel_slow) begin
					sw_q <= SW_SLOW;
				end else if (!slow_flag_q && fast_flag_q) begin
					sw_q <= SW_EDGE;
				end
				SW_EDGE: if (sel_slow) begin
					sw_q <= SW_SLOW; // fast rc already stopped, no edge will come
				end else if (fast_rc_tick) begin
					sw_q <= SW_FAST;
				end
				SW_FAST: if (sel_slow) begin
					sw_q <= SW_SLOW;
				end
			endcase
		end
	end

	assign sw_done = (sw_q == SW_EDGE) && fast_rc_tick && !sel_slow;

	// fast flag sets after two fast ticks once past warm-up
	always_ff @(posedge sys_clk) begin
		if (!rstn || sw_q == SW_SLOW || sw_q == SW_WARM) begin
			fast_cnt_q  <= 2'd0;
			fast_flag_q <= 1'b0;
		end else if (fast_rc_tick && !fast_flag_q) begin
			fast_cnt_q  <= fast_cnt_q + 2'd1;
			fast_flag_q <= (fast_cnt_q == `CKSRS_FAST_RDY - 2'd1);
		end
	end

	// slow flag only while the wakeup clock runs and has settled
	always_ff @(posedge sys_clk) begin
		if (!rstn || !osc.wakeup_en || (sw_q != SW_SLOW && opt != CKSRS_OPT_EXT_CLK)) begin
			settle_q    <= 3'd0;
			slow_flag_q <= 1'b0;
		end else if (slow_osc_tick && !slow_flag_q) begin
			settle_q    <= settle_q + 3'd1;
			slow_flag_q <= (settle_q == 3'(SLOW_SETTLE - 1));
		end
	end

	// the wakeup oscillator drops once running from fast rc, except in auto-wakeup halt or with the external clock option
	assign osc.fast_rc_en = !sel_slow;
	assign osc.wakeup_en  = (sw_q != SW_FAST)
		|| halt_awu
		|| opt == CKSRS_OPT_EXT_CLK;
	assign osc.on_fast    = (sw_q == SW_FAST);

	// trim fields drive the fast rc directly
	assign rc_trim_high = trim_q[`CKSRS_TRIM_HI_LSB +: 8];
	assign rc_trim_low  = trim_q[`CKSRS_TRIM_LO_LSB +: 2];

	////////////////////////////////////////////////////////////////////////////////
	// reset sequencer

	logic       any_src;
	logic [9:0] dly_q;
	logic [9:0] dly_len;
	logic [1:0] fetch_q;

	assign any_src = rst_src.ext_pulse || rst_src.low_voltage_detect_reset
		|| rst_src.watchdog || rst_src.illegal_code;
	assign dly_len = (opt == CKSRS_OPT_SLOW_RC) ? `CKSRS_DLY_SHORT : `CKSRS_DLY_LONG;

	// a source restarts the sequence from any phase
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			rs_q    <= RS_ACTIVE;
			dly_q   <= 10'd0;
			fetch_q <= 2'd0;
		end else if (any_src) begin
			rs_q <= RS_ACTIVE;
		end else begin
			unique case (rs_q)
				RS_IDLE: ;
				RS_ACTIVE: begin
					rs_q  <= RS_DELAY;
					dly_q <= 10'd0;
				end
				RS_DELAY: begin
					dly_q <= dly_q + 10'd1;
					if (dly_q == dly_len - 10'd1) begin
						rs_q    <= RS_FETCH;
						fetch_q <= 2'd0;
					end
				end
				RS_FETCH: begin
					fetch_q <= fetch_q + 2'd1;
					if (fetch_q == `CKSRS_FETCH_CYC - 2'd1) begin
						rs_q <= RS_IDLE;
					end
				end
			endcase
		end
	end

	assign rs_done      = (rs_q == RS_FETCH) && !any_src && (fetch_q == `CKSRS_FETCH_CYC - 2'd1);
	assign pin_low      = (rs_q == RS_ACTIVE) || (rs_q == RS_DELAY);
	assign reset_pin_drive = 1'b0;
	assign reset_pin_oe = pin_low;
	// an outside low on the pin during blank flash keeps the cpu in reset
	assign cpu_reset    = (rs_q != RS_IDLE) || !reset_pin_level;
	assign vec_fetch    = (rs_q == RS_FETCH);
	assign vec_addr     = `CKSRS_VECTOR + {15'h0, fetch_q[0]};

	// prog clock pin is input with pull-up unless software drives it
	assign prog_clock_pin_oe = ctrl_q[`CKSRS_CTRL_PCK_OUT] && !cpu_reset;
	assign prog_clock_pin_drive = ctrl_q[`CKSRS_CTRL_PCK_DAT];
	assign prog_clock_pullup = !prog_clock_pin_oe;

	////////////////////////////////////////////////////////////////////////////////
	// assertions

	sequence s_src;
		any_src;
	endsequence

	sequence s_src_ends;
		any_src ##1 !any_src;
	endsequence

	sequence s_delay_low;
		rs_q == RS_DELAY && reset_pin_oe && !reset_pin_drive;
	endsequence

	a_fast_enable: assert property (@(posedge sys_clk) disable iff (!rstn)
		!sel_slow |-> osc.fast_rc_en) else $error("fast rc not enabled");
	a_fast_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
		sel_slow |-> !osc.fast_rc_en) else $error("fast rc running unselected");
	a_warm_exit: assert property (@(posedge sys_clk) disable iff (!rstn)
		sw_q == SW_WARM && $past(sw_q) == SW_WARM ##1 sw_q == SW_WAIT |-> $past(warm_q) == 4'h7)
		else $error("warm count wrong");
	a_wait_flags: assert property (@(posedge sys_clk) disable iff (!rstn)
		sw_q == SW_WAIT ##1 sw_q == SW_EDGE |-> $past(fast_flag_q) && !$past(slow_flag_q))
		else $error("switch before flags");
	a_switch_edge: assert property (@(posedge sys_clk) disable iff (!rstn)
		sw_q == SW_EDGE ##1 sw_q == SW_FAST |-> $past(fast_rc_tick)) else $error("switch off edge");
	a_slow_stop: assert property (@(posedge sys_clk) disable iff (!rstn)
		sw_q == SW_FAST && !halt_awu && opt != CKSRS_OPT_EXT_CLK |-> !osc.wakeup_en)
		else $error("wakeup osc not stopped");
	a_ext_wakeup: assert property (@(posedge sys_clk) disable iff (!rstn)
		opt == CKSRS_OPT_EXT_CLK || halt_awu |-> osc.wakeup_en) else $error("wakeup osc off");
	a_src_pin: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_src |=> reset_pin_oe && !reset_pin_drive) else $error("reset pin not low");
	a_delay_start: assert property (@(posedge sys_clk) disable iff (!rstn)
		s_src_ends |=> s_delay_low) else $error("delay phase not entered with pin low");
	a_delay_len: assert property (@(posedge sys_clk) disable iff (!rstn)
		rs_q == RS_DELAY ##1 rs_q == RS_FETCH |-> $past(dly_q) == dly_len - 10'd1)
		else $error("delay length wrong");
	a_fetch_two: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(vec_fetch) && !any_src |-> vec_addr == 16'hfffe ##1 any_src || vec_addr == 16'hffff)
		else $error("vector fetch wrong");
	a_pck_input: assert property (@(posedge sys_clk) disable iff (!rstn)
		cpu_reset |-> !prog_clock_pin_oe && prog_clock_pullup) else $error("prog pin driven");
	a_illegal_rst: assert property (@(posedge sys_clk) disable iff (!rstn)
		rst_src.illegal_code |=> rs_q == RS_ACTIVE && cpu_reset) else $error("illegal code ignored");
	a_fast_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(fast_flag_q) |-> $past(fast_rc_tick) && $past(fast_cnt_q) == `CKSRS_FAST_RDY - 2'd1)
		else $error("fast flag early");
	a_slow_ready: assert property (@(posedge sys_clk) disable iff (!rstn)
		$rose(slow_flag_q) |-> $past(osc.wakeup_en) && $past(slow_osc_tick))
		else $error("slow flag without clock");
	// hazard: a status read in the same cycle as an event must not lose it
	a_irq_wins: assert property (@(posedge sys_clk) disable iff (!rstn)
		sw_done || rs_done |=>
			(irq_st_q & $past({rs_done, sw_done})) == $past({rs_done, sw_done}))
		else $error("event lost");
	a_ack_req: assert property (@(posedge sys_clk) disable iff (!rstn)
		wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");

endmodule

// ---- tb/cksrs_osc_model.sv ----
// oscillators and external reset pin facing the clock switch and reset sequencer
// assumes the bench shares sys_clk; oscillator edges are one-cycle pulses
`timescale 1ns/1ps
module cksrs_osc_model #(
	parameter int FAST_DIV = 3,
	parameter int SLOW_DIV = 5
) (
	input  wire logic sys_clk,
	input  wire logic fast_en,
	input  wire logic slow_en,
	input  wire logic hold_low,
	input  wire logic pin_oe,
	input  wire logic pin_o,
	output logic      fast_tick,
	output logic      slow_tick,
	output logic      pin_i
);
	int fc_q = 0;
	int sc_q = 0;
	////////////////////////////////////////////////////////////////////////////////
	// ticks start at zero so the design never sees an unknown edge
	initial begin
		fast_tick = 1'b0;
		slow_tick = 1'b0;
	end
	// a disabled oscillator gives no edges at all, as the real one would
	always @(posedge sys_clk) begin
		fc_q <= fast_en ? (fc_q + 1) % FAST_DIV : 0;
		sc_q <= slow_en ? (sc_q + 1) % SLOW_DIV : 0;
		fast_tick <= fast_en && fc_q == FAST_DIV - 1;
		slow_tick <= slow_en && sc_q == SLOW_DIV - 1;
	end
	// pulled-up pin; the external tool may hold it low while flash is blank
	assign pin_i = ((pin_oe && !pin_o) || hold_low) ? 1'b0 : 1'b1;
endmodule

// ---- tb/tb.sv ----
// self-checking bench for the clock switch and reset sequencer
// assumes the oscillator model in tb/ and the design package and defines
`timescale 1ns/1ps
`include "cksrs_defines.svh"
module tb import cksrs_pkg::*;;
	logic          sys_clk = 1'b0;
	logic          rstn = 1'b0;
	logic [7:0]    adr = 8'h00;
	logic [31:0]   wdat = 32'h0;
	logic          we = 1'b0;
	logic [3:0]    sel = 4'h0;
	logic          cyc = 1'b0;
	logic          stb = 1'b0;
	logic          halt_awu = 1'b0;
	logic          hold_low = 1'b0;
	cksrs_src_type src = '0;
	cksrs_osc_type osc;
	logic [31:0]   rdat, rd;
	logic          ack, irq, ftick, stick, pin_i, pin_o, pin_oe, pck_o, pck_oe, pck_pu;
	logic [7:0]    trim_hi;
	logic [1:0]    trim_lo;
	logic          cpu_reset, vfetch, lt;
	logic [15:0]   vaddr;
	int            n_fail = 0;
	int            n_checks = 0;
	int            n, t;
	////////////////////////////////////////////////////////////////////////////////
	cksrs_top #(.SLOW_SETTLE(2)) i_dut (.sys_clk(sys_clk), .rstn(rstn), .wb_adr_i(adr),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_ack_o(ack), .irq(irq), .fast_rc_tick(ftick),
		.slow_osc_tick(stick), .halt_awu(halt_awu), .rst_src(src), .reset_pin_level(pin_i),
		.reset_pin_drive(pin_o), .reset_pin_oe(pin_oe), .prog_clock_pin_level(1'b1),
		.prog_clock_pin_drive(pck_o), .prog_clock_pin_oe(pck_oe), .prog_clock_pullup(pck_pu),
		.osc(osc), .rc_trim_high(trim_hi), .rc_trim_low(trim_lo), .cpu_reset(cpu_reset),
		.vec_fetch(vfetch), .vec_addr(vaddr));
	cksrs_osc_model i_osc (.sys_clk(sys_clk), .fast_en(osc.fast_rc_en),
		.slow_en(osc.wakeup_en), .hold_low(hold_low), .pin_oe(pin_oe), .pin_o(pin_o),
		.fast_tick(ftick), .slow_tick(stick), .pin_i(pin_i));
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: saw %h, expected %h", $time, got, exp);
		end
	endtask
	// classic single cycle; waits for ack under a bound, never a fixed count
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= s;
		@(posedge sys_clk);
		while (ack !== 1'b1 && k < 20) begin
			@(posedge sys_clk);
			k++;
		end
		chk(32'(k < 20), 32'h1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		wb(1'b0, a, 32'h0, 4'h0);
		chk(rd, exp);
	endtask
	// count the pin-low phase, then the two fetch cycles
	task automatic seq(input int d);
		n = 0;
		while (pin_oe === 1'b1 && n < 600) begin
			@(posedge sys_clk);
			n++;
		end
		chk(32'(n >= d && n <= d + 3), 32'h1);
		chk({vfetch, vaddr}, {1'b1, 16'hfffe});
		@(posedge sys_clk);
		chk({vfetch, vaddr}, {1'b1, 16'hffff});
		@(posedge sys_clk);
		chk({vfetch, cpu_reset}, 2'b00);
	endtask
	task automatic pulse(input int b);
		src <= cksrs_src_type'(4'h1 << b);
		repeat (3) @(posedge sys_clk);
		chk({pck_oe, pck_pu, pin_oe, pin_i}, 4'b0110);
		src <= '0;
		@(posedge sys_clk);
	endtask
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// a full run is a few thousand cycles; this cuts a hang short
	initial begin
		#(50 * 20000);
		n_fail++;
		report_and_stop();
	end
	initial begin
		repeat (6) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		chk({pin_oe, cpu_reset, osc.fast_rc_en, pck_pu, trim_hi, trim_lo}, 14'h3402);
		seq(512);
		rchk(`CKSRS_OFF_CTRL, 32'h01);
		rchk(`CKSRS_OFF_STAT, 32'h08);
		rchk(`CKSRS_OFF_IRQS, 32'h02);
		rchk(`CKSRS_OFF_IRQS, 32'h00);
		rchk(8'h20, 32'h0);
		wb(1'b1, `CKSRS_OFF_TRIM, 32'h3a5, 4'h3);
		chk({trim_hi, trim_lo}, {8'ha5, 2'b11});
		wb(1'b1, `CKSRS_OFF_IRQM, 32'h3, 4'h1);
		// every source once, each option byte clock source at least once
		for (int i = 0; i < 4; i++) begin
			wb(1'b1, `CKSRS_OFF_CTRL, 32'(4'h9 | ((i % 3) << 1)), 4'h1);
			chk(pck_oe, 1'b1);
			pulse(i);
			seq(i % 3 == 1 ? 256 : 512);
			@(posedge sys_clk);
			chk(irq, 1'b1);
			rchk(`CKSRS_OFF_IRQS, 32'h2);
			chk(irq, 1'b0);
		end
		hold_low <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk(cpu_reset, 1'b1);
		hold_low <= 1'b0;
		repeat (3) @(posedge sys_clk);
		chk(cpu_reset, 1'b0);
		// changeover to the fast oscillator, counting its edges on the way
		wb(1'b1, `CKSRS_OFF_CTRL, 32'h18, 4'h1);
		chk(osc.fast_rc_en, 1'b1);
		chk({pck_oe, pck_o}, 2'b11);
		t = 0;
		n = 0;
		while (osc.on_fast !== 1'b1 && n < 300) begin
			lt = ftick;
			t += int'(ftick);
			@(posedge sys_clk);
			n++;
		end
		chk(32'(t >= 10 && t <= 12), 32'h1);
		chk(lt, 1'b1);
		chk(osc.wakeup_en, 1'b0);
		rchk(`CKSRS_OFF_STAT, 32'h14);
		rchk(`CKSRS_OFF_IRQS, 32'h1);
		halt_awu <= 1'b1;
		repeat (2) @(posedge sys_clk);
		chk(osc.wakeup_en, 1'b1);
		halt_awu <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(osc.wakeup_en, 1'b0);
		wb(1'b1, `CKSRS_OFF_CTRL, 32'h0c, 4'h1);
		chk(osc.wakeup_en, 1'b1);
		wb(1'b1, `CKSRS_OFF_CTRL, 32'h01, 4'h1);
		chk(osc.fast_rc_en, 1'b0);
		n = 0;
		do begin
			wb(1'b0, `CKSRS_OFF_STAT, 32'h0, 4'h0);
			n++;
		end while (rd[3] !== 1'b1 && n < 20);
		chk(rd, 32'h08);
		report_and_stop();
	end
endmodule
